// file: rtl/celc_divider.sv
/*
 Enabled tick divider: one-cycle tick every DIV cycles while run is high.
 Assumes run is synchronous to pclk; stopping clears the phase.
*/
`timescale 1ns/100ps
module celc_divider #(
	parameter int unsigned DIV = 2
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic run,
	output logic      tick
);
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	logic        tick_reg;
	logic        tick_next;
	logic        wrap;

	always_comb begin
		wrap      = (cnt_reg == 16'(DIV - 1));
		cnt_next  = 16'h0000;
		tick_next = 1'b0;
		if (run) begin
			cnt_next  = wrap ? 16'h0000 : cnt_reg + 16'h0001;
			tick_next = wrap;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg  <= 16'h0000;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule // celc_divider

// file: rtl/celc_pkg.sv
/*
 Types of the clock-enable and level-code block.
 Assumes nothing of its surroundings.
*/
package celc_pkg;

	// Decoded levels, signed eighths of a dB
	typedef struct packed {
		logic [11:0] in_gain;
		logic [11:0] ng_thresh;
		logic [11:0] out_atten;
	} celc_level_t;

	typedef struct packed {
		logic srg_run;
		logic scg_run;
	} celc_status_t;

endpackage

// file: rtl/celc_regs.svh
/*
 Register offsets, field positions, reset values and timing counts
 of the clock-enable and level-code block.
 Assumes an 18-bit APB byte address and 32-bit data.
*/
`ifndef CELC_REGS_SVH
`define CELC_REGS_SVH

// Register indices; byte address is four times the index
`define CELC_CLK_EN_IDX      18'h040fa
`define CELC_IN_VOL_IDX      18'h04100
`define CELC_NG_THR_IDX      18'h04101
`define CELC_OUT_ATT_IDX     18'h04102
`define CELC_STATUS_IDX      18'h04103
`define CELC_CLK_EN_ADDR     (`CELC_CLK_EN_IDX << 2)
`define CELC_IN_VOL_ADDR     (`CELC_IN_VOL_IDX << 2)
`define CELC_NG_THR_ADDR     (`CELC_NG_THR_IDX << 2)
`define CELC_OUT_ATT_ADDR    (`CELC_OUT_ATT_IDX << 2)
`define CELC_STATUS_ADDR     (`CELC_STATUS_IDX << 2)

// Clock-enable fields
`define CELC_SRG_EN_BIT      0
`define CELC_SCG_EN_BIT      1
`define CELC_CLK_EN_RESET    2'h0

// Code fields and reset values
`define CELC_IN_VOL_RESET    6'h10
`define CELC_NG_THR_RESET    5'h00
`define CELC_OUT_ATT_RESET   8'h00
`define CELC_DECODE_LSB      16

// Decode in eighths of a dB: offset and step per code
`define CELC_IN_GAIN_OFS     12'h060
`define CELC_IN_GAIN_STEP    12'h006
`define CELC_NG_OFS          12'h264
`define CELC_NG_STEP         12'h00c
`define CELC_ATT_STEP        12'h003

// Generator timing: dividers in pclk cycles, then the last bit count of a frame half
`define CELC_SRATE_DIV       2083
`define CELC_BCLK_HALF_DIV   16
`define CELC_BCLK_PER_HALF   5'h1f

`endif

// file: rtl/celc_top.sv
/*
 Clock-generator enables and level-code decoders, APB slave.
 Assumes APB3 master on pclk; master_mode comes from serial port setup.
*/
`timescale 1ns/100ps
`include "celc_regs.svh"
module celc_top import celc_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        master_mode,
	output logic             sample_rate_generator_enable,
	output logic             serial_clock_generator_enable,
	output logic             sample_rate_tick,
	output logic             bclk_out,
	output logic             lrclk_out,
	output celc_level_t      level_out
);
	logic [1:0]   clk_en_reg;
	logic [1:0]   clk_en_next;
	logic [5:0]   in_vol_reg;
	logic [5:0]   in_vol_next;
	logic [4:0]   ng_thr_reg;
	logic [4:0]   ng_thr_next;
	logic [7:0]   out_att_reg;
	logic [7:0]   out_att_next;
	celc_level_t  level_reg;
	celc_level_t  level_next;
	logic [31:0]  prdata_reg;
	logic [31:0]  prdata_next;
	logic         bclk_reg;
	logic         bclk_next;
	logic         lrclk_reg;
	logic         lrclk_next;
	logic [4:0]   bcnt_reg;
	logic [4:0]   bcnt_next;
	logic         srg_run;
	logic         scg_run;
	logic         srg_tick;
	logic         half_tick;
	logic         setup;
	logic         access;
	logic         wr;
	logic         mapped;
	celc_status_t status;

	// Level decoders, all in eighths of a dB
	function automatic logic [11:0] dec_in_gain(input logic [5:0] code);
		dec_in_gain = {6'h00, code} * `CELC_IN_GAIN_STEP - `CELC_IN_GAIN_OFS;
	endfunction

	function automatic logic [11:0] dec_ng(input logic [4:0] code);
		dec_ng = {7'h00, code} * `CELC_NG_STEP - `CELC_NG_OFS;
	endfunction

	function automatic logic [11:0] dec_att(input logic [7:0] code);
		dec_att = {4'h0, code} * `CELC_ATT_STEP;
	endfunction

	// APB decode; no wait states
	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign wr     = access && pwrite;
	assign mapped = (paddr == `CELC_CLK_EN_ADDR) || (paddr == `CELC_IN_VOL_ADDR) ||
	                (paddr == `CELC_NG_THR_ADDR) || (paddr == `CELC_OUT_ATT_ADDR) ||
	                (paddr == `CELC_STATUS_ADDR);
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	assign srg_run       = clk_en_reg[`CELC_SRG_EN_BIT];
	assign scg_run       = clk_en_reg[`CELC_SCG_EN_BIT] && master_mode;
	assign status.srg_run = srg_run;
	assign status.scg_run = scg_run;

	// Register writes
	always_comb begin
		clk_en_next  = clk_en_reg;
		in_vol_next  = in_vol_reg;
		ng_thr_next  = ng_thr_reg;
		out_att_next = out_att_reg;
		if (wr) begin
			unique case (paddr)
				`CELC_CLK_EN_ADDR:  clk_en_next  = pwdata[1:0];
				`CELC_IN_VOL_ADDR:  in_vol_next  = pwdata[5:0];
				`CELC_NG_THR_ADDR:  ng_thr_next  = pwdata[4:0];
				`CELC_OUT_ATT_ADDR: out_att_next = pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_en_reg  <= `CELC_CLK_EN_RESET;
			in_vol_reg  <= `CELC_IN_VOL_RESET;
			ng_thr_reg  <= `CELC_NG_THR_RESET;
			out_att_reg <= `CELC_OUT_ATT_RESET;
		end else begin
			clk_en_reg  <= clk_en_next;
			in_vol_reg  <= in_vol_next;
			ng_thr_reg  <= ng_thr_next;
			out_att_reg <= out_att_next;
		end
	end

	// Decoded levels follow the codes one cycle later
	always_comb begin
		level_next.in_gain   = dec_in_gain(in_vol_reg);
		level_next.ng_thresh = dec_ng(ng_thr_reg);
		level_next.out_atten = dec_att(out_att_reg);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_reg <= '0;
		end else begin
			level_reg <= level_next;
		end
	end

	// Read data captured in setup, shown in access
	always_comb begin
		prdata_next = prdata_reg;
		if (setup) begin
			prdata_next = 32'h0000_0000;
			unique case (paddr)
				`CELC_CLK_EN_ADDR:  prdata_next[1:0] = clk_en_reg;
				`CELC_IN_VOL_ADDR: begin
					prdata_next[5:0] = in_vol_reg;
					prdata_next[27:16] = level_reg.in_gain;
				end
				`CELC_NG_THR_ADDR: begin
					prdata_next[4:0] = ng_thr_reg;
					prdata_next[27:16] = level_reg.ng_thresh;
				end
				`CELC_OUT_ATT_ADDR: begin
					prdata_next[7:0] = out_att_reg;
					prdata_next[27:16] = level_reg.out_atten;
				end
				`CELC_STATUS_ADDR:  prdata_next[1:0] = status;
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else begin
			prdata_reg <= prdata_next;
		end
	end

	// Sample-rate generator
	celc_divider #(
		.DIV (`CELC_SRATE_DIV)
	) u_srg (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (srg_run),
		.tick    (srg_tick)
	);

	// Serial clock generator half-period timer
	celc_divider #(
		.DIV (`CELC_BCLK_HALF_DIV)
	) u_scg (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (scg_run),
		.tick    (half_tick)
	);

	// Bit and frame clocks, parked low when not master or disabled
	always_comb begin
		bclk_next  = 1'b0;
		lrclk_next = 1'b0;
		bcnt_next  = 5'h00;
		if (scg_run) begin
			bclk_next  = bclk_reg ^ half_tick;
			lrclk_next = lrclk_reg;
			bcnt_next  = bcnt_reg;
			if (half_tick && bclk_reg) begin
				bcnt_next = bcnt_reg + 5'h01;
				if (bcnt_reg == `CELC_BCLK_PER_HALF) begin
					lrclk_next = ~lrclk_reg;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bclk_reg  <= 1'b0;
			lrclk_reg <= 1'b0;
			bcnt_reg  <= 5'h00;
		end else begin
			bclk_reg  <= bclk_next;
			lrclk_reg <= lrclk_next;
			bcnt_reg  <= bcnt_next;
		end
	end

	assign prdata                        = prdata_reg;
	assign sample_rate_generator_enable  = clk_en_reg[`CELC_SRG_EN_BIT];
	assign serial_clock_generator_enable = clk_en_reg[`CELC_SCG_EN_BIT];
	assign sample_rate_tick              = srg_tick && srg_run;
	assign bclk_out                      = bclk_reg;
	assign lrclk_out                     = lrclk_reg;
	assign level_out                     = level_reg;

	// Checks
	logic [15:0] gap_reg;
	logic [15:0] gap_next;

	always_comb begin
		gap_next = (!srg_run || sample_rate_tick) ? 16'h0000 : gap_reg + 16'h0001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_reg <= 16'h0000;
		end else begin
			gap_reg <= gap_next;
		end
	end

	sequence wr_clk_en_s;
		psel && penable && pwrite && (paddr == `CELC_CLK_EN_ADDR);
	endsequence

	sequence srg_off_s;
		!srg_run [*2];
	endsequence

	sequence scg_off_s;
		!scg_run;
	endsequence

	srg_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clk_en_s |=> sample_rate_generator_enable == $past(pwdata[0]))
		else $error("sample-rate enable did not follow write");

	scg_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_clk_en_s |=> serial_clock_generator_enable == $past(pwdata[1]))
		else $error("serial clock enable did not follow write");

	srg_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		srg_off_s |-> !srg_tick)
		else $error("sample tick while generator off");

	srg_period_a: assert property (@(posedge pclk) disable iff (!presetn)
		gap_reg <= 16'(`CELC_SRATE_DIV))
		else $error("sample tick missing");

	bclk_source_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(bclk_out) |-> $past(scg_run))
		else $error("bit clock rose outside master mode");

	scg_park_a: assert property (@(posedge pclk) disable iff (!presetn)
		scg_off_s |=> !bclk_out && !lrclk_out)
		else $error("serial clocks not parked");

	lrclk_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(lrclk_out) && $past(scg_run) |-> $fell(bclk_out))
		else $error("frame clock moved off bit clock fall");

	in_gain_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(in_vol_reg) |=> (level_out.in_gain + 12'h060) == 12'($past(in_vol_reg)) * 12'h006)
		else $error("input gain decode wrong");

	ng_thresh_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(ng_thr_reg) |=> (level_out.ng_thresh + 12'h264) == 12'($past(ng_thr_reg)) * 12'h00c)
		else $error("gate threshold decode wrong");

	out_att_a: assert property (@(posedge pclk) disable iff (!presetn)
		(out_att_reg == 8'h00) [*2] |-> level_out.out_atten == 12'h000)
		else $error("zero code not zero attenuation");

	att_step_a: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(out_att_reg) |=> level_out.out_atten == 12'($past(out_att_reg)) * 12'h003)
		else $error("attenuation step wrong");

endmodule // celc_top

// file: tb/tb.sv
/*
 Self-checking bench for the clock-enable and level-code block.
 Assumes the APB slave answers with pready and a 100 MHz pclk.
*/
`timescale 1ns/100ps
`include "celc_regs.svh"
module tb;
	import celc_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, master_mode;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        srg_en, scg_en, tick, bclk, lrclk, er;
	celc_level_t lvl;
	int          n_mismatch, checks_done, n, i;
	logic [17:0] la [8];
	logic [7:0]  lc [8];
	logic [11:0] ld [8];

	celc_top u_celc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .master_mode(master_mode), .sample_rate_generator_enable(srg_en),
		.serial_clock_generator_enable(scg_en), .sample_rate_tick(tick), .bclk_out(bclk),
		.lrclk_out(lrclk), .level_out(lvl));

	always #5 pclk = ~pclk;

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; called right after a rising edge
	task xfer(input logic w, input logic [17:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			n_mismatch++;
			print_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Cycles until s goes high, bounded
	task wait_hi(input int sel, input int lim);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while ((sel == 0 ? tick : sel == 1 ? bclk : lrclk) !== 1'b1 && n < lim);
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, master_mode} = 4'h0;
		paddr = 18'h00000;
		pwdata = 32'h00000000;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		xfer(1'b0, `CELC_CLK_EN_ADDR, 32'h0);
		chk(rd, 32'h0);
		chk({srg_en, scg_en, tick, bclk}, 32'h0);
		// Sample-rate generator: first tick, exact period, then silence
		xfer(1'b1, `CELC_CLK_EN_ADDR, 32'h1);
		chk(srg_en, 1'b1);
		wait_hi(0, 3000);
		chk(n >= 2080 && n <= 2085, 1'b1);
		wait_hi(0, 3000);
		chk(n, 2083);
		xfer(1'b1, `CELC_CLK_EN_ADDR, 32'h0);
		chk(srg_en, 1'b0);
		wait_hi(0, 2200);
		chk(tick, 1'b0);
		// Serial clocks only when master
		xfer(1'b1, `CELC_CLK_EN_ADDR, 32'h2);
		xfer(1'b0, `CELC_CLK_EN_ADDR, 32'h0);
		chk(rd, 32'h2);
		wait_hi(1, 60);
		chk({bclk, lrclk}, 2'h0);
		master_mode <= 1'b1;
		wait_hi(1, 40);
		chk(n >= 16 && n <= 19, 1'b1);
		n = 0;
		while (bclk === 1'b1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		chk(n, 16);
		wait_hi(2, 1200);
		chk(n >= 960 && n <= 1060, 1'b1);
		xfer(1'b1, `CELC_CLK_EN_ADDR, 32'h3);
		xfer(1'b0, `CELC_STATUS_ADDR, 32'h0);
		chk(rd, 32'h3);
		master_mode <= 1'b0;
		xfer(1'b1, `CELC_CLK_EN_ADDR, 32'h1);
		repeat (2) @(posedge pclk);
		chk({bclk, lrclk, scg_en}, 3'h0);
		// Level decoders, eighths of a dB
		la = '{`CELC_IN_VOL_ADDR, `CELC_IN_VOL_ADDR, `CELC_IN_VOL_ADDR, `CELC_IN_VOL_ADDR,
			`CELC_NG_THR_ADDR, `CELC_NG_THR_ADDR, `CELC_OUT_ATT_ADDR, `CELC_OUT_ATT_ADDR};
		lc = '{8'h00, 8'h01, 8'h10, 8'h3f, 8'h00, 8'h1f, 8'h01, 8'hff};
		ld = '{12'hfa0, 12'hfa6, 12'h000, 12'h11a, 12'hd9c, 12'hf10, 12'h003, 12'h2fd};
		for (i = 0; i < 8; i++) begin
			xfer(1'b1, la[i], {24'h0, lc[i]});
			xfer(1'b0, la[i], 32'h0);
			chk(rd, {4'h0, ld[i], 8'h00, lc[i]});
			chk(i < 4 ? lvl.in_gain : i < 6 ? lvl.ng_thresh : lvl.out_atten, ld[i]);
		end
		// Unmapped place and read-only status
		xfer(1'b1, 18'h10410, 32'hffffffff);
		chk(er, 1'b1);
		xfer(1'b0, 18'h10410, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		xfer(1'b1, `CELC_STATUS_ADDR, 32'h3);
		xfer(1'b0, `CELC_STATUS_ADDR, 32'h0);
		chk(rd, 32'h2);
		xfer(1'b1, `CELC_CLK_EN_ADDR, 32'h0);
		chk(srg_en, 1'b0);
		print_verdict();
	end
endmodule // tb
